/* File: core/pmc_regs.vh */
// constants of the per-link performance counter bank: ranges, item codes,
// classification thresholds and timing counts.
// assumes a one-second tick on the core clock; included by its bare name.
// How it works
// RULE1: per link, interval errored seconds, 0..1000, refreshed each second.
// RULE2: per link, interval unavailable, severe, bursty seconds, 0..900, per second.
// RULE3: elapsed seconds of current quarter-hour, 0..900, refreshed each second.
// RULE4: per link, interval frame losses and slip seconds, 0..255, per second.
// RULE5: per link, daily errored seconds, 0..900, refreshed every quarter hour.
// RULE6: daily unavailable, severe, bursty seconds, 16 bits, per quarter hour.
// RULE7: daily frame losses and slip seconds, 0..255, per quarter hour.
// RULE8: completed quarter hours in current day, 0..96, per quarter hour.
// RULE9: CRC events since last clear on CRC links, 0..1000, per second.
// RULE10: average CRC events per second since last clear, 0..1000.
// RULE11: bipolar violations of the last full minute, 0..9999, per minute.
// RULE12: worst-minute bipolar violations since clear, 0..9999, per minute.
// RULE13: degraded minutes in current day, 0..1440, per minute.
// RULE14: degraded minutes of previous day, 0..1440, replaced daily.
// RULE15: four independent statistic sets, selected by link number.
// RULE16: CRC links offer CRC items, other links offer bipolar items.
// RULE17: stepping selects next item of the link, wrapping after the last.
// RULE18: clearing any interval or daily item clears all correlated link counters.
// RULE19: clearing last-minute or worst-minute bipolar count clears both; at a minute end both take that minute's count.
// RULE20: CRC event counter clears alone and exists only with CRC enabled.
// RULE21: supervisory clear-all option clears every statistic of every link; at a minute end the bipolar counts take the minute result instead.
// RULE22: severe second has 832 or more CRC events or any out-of-frame.
// RULE23: bursty second has 2 to 831 CRC events.
// RULE24: failed state after 10 severe seconds, left after 10 clean.
// RULE25: errored second has any CRC, out-of-frame or slip event.
// RULE26: counters saturate at their range maximum instead of wrapping.
// RULE27: at 900 seconds fold interval into daily; restart day after 96.
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

`define PMC_SECS_PER_INT 10'h384
`define PMC_INT_PER_DAY 7'h60
`define PMC_LAST_SEC_OF_MIN 6'h3b
`define PMC_SES_CRC_MIN 10'h340
`define PMC_BES_CRC_MIN 10'h002
`define PMC_FAIL_RUN 4'ha
`define PMC_SEC_CRC_MAX 10'h3ff
`define PMC_SEC_LOF_MAX 8'hff
`define PMC_AVG_SECS_MAX 20'hfffff
`define PMC_CNT_RST 16'h0000

`define PMC_INT_ES_MAX 16'h03e8
`define PMC_INT_SEC_MAX 16'h0384
`define PMC_EVT_MAX 16'h00ff
`define PMC_DAY_ES_MAX 16'h0384
`define PMC_DAY_SEC_MAX 16'hffff
`define PMC_CRC_MAX 16'h03e8
`define PMC_AVG_MAX 10'h3e8
`define PMC_BPV_MAX 14'h270f
`define PMC_DEG_MAX 16'h05a0
`define PMC_DEG_BPV_LIMIT 14'h007a

`define PMC_IT_INT_ES 5'h00
`define PMC_IT_INT_UAS 5'h01
`define PMC_IT_ELAPSED 5'h02
`define PMC_IT_INT_SES 5'h03
`define PMC_IT_INT_BES 5'h04
`define PMC_IT_INT_LOF 5'h05
`define PMC_IT_INT_CSS 5'h06
`define PMC_IT_DAY_ES 5'h07
`define PMC_IT_DAY_UAS 5'h08
`define PMC_IT_DAY_SES 5'h09
`define PMC_IT_DAY_BES 5'h0a
`define PMC_IT_DAY_LOF 5'h0b
`define PMC_IT_DAY_CSS 5'h0c
`define PMC_IT_DAY_INT 5'h0d
`define PMC_IT_CRC_CNT 5'h0e
`define PMC_IT_CRC_AVG 5'h0f
`define PMC_IT_DEG_TODAY 5'h10
`define PMC_IT_DEG_PREV 5'h11
`define PMC_IT_BPV_LAST 5'h12
`define PMC_IT_BPV_PEAK 5'h13
`define PMC_IT_CRC_LAST 5'h11
`define PMC_IT_BPV_FIRST 5'h10
`define PMC_IT_BPV_END 5'h13

`endif

/* File: core/pmc_sat_cnt.v */
// saturating accumulator used for the interval, daily, CRC-count and degraded-minute statistics.
// assumes clear, enable and load come from logic on the core clock.
`timescale 1ns/1ps
`default_nettype none
module pmc_sat_cnt #(
	parameter W = 16,
	parameter [W-1:0] MAX = {W{1'b1}}
) (
	input wire core_clk_i,
	input wire rst_i,
	input wire clr_i,
	input wire en_i,
	input wire ld_i,
	input wire [W-1:0] add_i,
	output wire [W-1:0] cnt_o
);
	reg [W-1:0] cnt_q;
	wire [W-1:0] base;
	wire [W:0] sum;

	// load restarts from zero so a fold can seed a fresh period
	assign base = ld_i ? {W{1'b0}} : cnt_q;
	assign sum = {1'b0, base} + {1'b0, add_i};
	assign cnt_o = cnt_q;

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= {W{1'b0}};
		end else if (clr_i) begin
			cnt_q <= {W{1'b0}};
		end else if (en_i) begin
			if (sum > {1'b0, MAX}) begin
				cnt_q <= MAX; // RULE26
			end else begin
				cnt_q <= sum[W-1:0];
			end
		end
	end
endmodule // pmc_sat_cnt
`default_nettype wire

/* File: core/pmc_top.v */
// performance statistics bank for four E1 links with item readout.
// assumes framer event pulses, the one-second tick and the panel and
// supervisory strobes are produced by logic on core_clk_i.
`timescale 1ns/1ps
`include "pmc_regs.vh"
`default_nettype none
module pmc_top (
	input wire core_clk_i,
	input wire rst_i,
	input wire sec_tick_i,
	input wire [3:0] crc_enable_i,
	input wire [3:0] crc_event_i,
	input wire [3:0] oof_event_i,
	input wire [3:0] slip_event_i,
	input wire [3:0] frame_loss_i,
	input wire [3:0] bpv_event_i,
	input wire [1:0] link_sel_i,
	input wire item_step_i,
	input wire clear_key_i,
	input wire clear_all_i,
	output wire [15:0] item_value_o,
	output wire [4:0] item_code_o,
	output wire [1:0] item_link_o,
	output wire [3:0] link_failed_o
);
	reg tick_q;
	reg [5:0] min_sec_q;
	reg [1:0] link_q;
	reg [4:0] item_q;
	reg [15:0] val_q;
	wire min_tick;
	wire sel_crc;
	wire [4:0] first_item;
	wire [4:0] last_item;
	wire cur_crc;
	wire key_corr;
	wire key_bpv;
	wire key_crc;
	wire key_avg;
	wire [63:0] link_val;

	assign item_value_o = val_q;
	assign item_code_o = item_q;
	assign item_link_o = link_q;

	// minute boundary shared by all links, one per sixty seconds
	assign min_tick = sec_tick_i && (min_sec_q == `PMC_LAST_SEC_OF_MIN);

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_q <= 1'b0;
			min_sec_q <= 6'h00;
		end else begin
			tick_q <= sec_tick_i;
			if (min_tick) begin
				min_sec_q <= 6'h00;
			end else if (sec_tick_i) begin
				min_sec_q <= min_sec_q + 6'h01;
			end
		end
	end

	// item list depends on the framing mode of the link being viewed
	assign sel_crc = crc_enable_i[link_sel_i]; // RULE16
	assign first_item = sel_crc ? `PMC_IT_INT_ES : `PMC_IT_BPV_FIRST;
	assign last_item = sel_crc ? `PMC_IT_CRC_LAST : `PMC_IT_BPV_END;

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			link_q <= 2'h0;
			item_q <= `PMC_IT_INT_ES;
		end else begin
			link_q <= link_sel_i; // RULE15
			if (link_sel_i != link_q) begin
				item_q <= first_item;
			end else if (sel_crc ? (item_q > `PMC_IT_CRC_LAST) :
				(item_q < `PMC_IT_BPV_FIRST)) begin
				item_q <= first_item; // RULE16
			end else if (item_step_i) begin
				if (item_q == last_item) begin
					item_q <= first_item; // RULE17
				end else begin
					item_q <= item_q + 5'h01; // RULE17
				end
			end
		end
	end

	// the panel key clears the item on show, with its coupled group
	assign cur_crc = crc_enable_i[link_q];
	assign key_corr = clear_key_i && ((item_q <= `PMC_IT_DAY_INT) ||
		(item_q == `PMC_IT_DEG_TODAY) || (item_q == `PMC_IT_DEG_PREV));
	assign key_bpv = clear_key_i && ((item_q == `PMC_IT_BPV_LAST) ||
		(item_q == `PMC_IT_BPV_PEAK));
	assign key_crc = clear_key_i && cur_crc && (item_q == `PMC_IT_CRC_CNT);
	assign key_avg = clear_key_i && cur_crc && (item_q == `PMC_IT_CRC_AVG);

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			val_q <= `PMC_CNT_RST;
		end else begin
			val_q <= link_val[{link_q, 4'h0} +: 16];
		end
	end

	genvar l;
	genvar k;
	generate
		for (l = 0; l < 4; l = l + 1) begin : g_link
			wire here;
			wire clr_corr;
			wire clr_bpv;
			wire clr_crc;
			wire clr_avg;
			wire es;
			wire ses;
			wire bes;
			wire fail_d;
			wire roll;
			wire new_day;
			wire min_deg;
			wire [95:0] int_add;
			wire [95:0] int_v;
			wire [95:0] day_v;
			wire [15:0] crc_cnt;
			wire [15:0] deg_today;
			reg [9:0] sc_q;
			reg oof_q;
			reg slip_q;
			reg [7:0] lof_q;
			reg [3:0] ses_run_q;
			reg [3:0] ok_run_q;
			reg failed_q;
			reg [9:0] elap_q;
			reg [6:0] intv_q;
			reg [31:0] sum_q;
			reg [19:0] secs_q;
			reg [31:0] rem_q;
			reg [9:0] quo_q;
			reg [9:0] avg_q;
			reg dv_busy_q;
			reg [13:0] bpv_q;
			reg [13:0] bpv_last_q;
			reg [13:0] bpv_peak_q;
			reg [15:0] deg_prev_q;
			reg [15:0] lv;

			assign here = (link_q == l);
			assign clr_corr = clear_all_i || (key_corr && here); // RULE18 RULE21
			assign clr_bpv = clear_all_i || (key_bpv && here); // RULE19 RULE21
			assign clr_crc = clear_all_i || (key_crc && here); // RULE20 RULE21
			assign clr_avg = clear_all_i || (key_avg && here);
			assign link_failed_o[l] = failed_q;

			// per-second tallies; an event on the tick opens the next second
			always @(posedge core_clk_i or posedge rst_i) begin
				if (rst_i) begin
					sc_q <= 10'h000;
					oof_q <= 1'b0;
					slip_q <= 1'b0;
					lof_q <= 8'h00;
				end else if (sec_tick_i) begin
					sc_q <= {9'h000, crc_event_i[l]};
					oof_q <= oof_event_i[l];
					slip_q <= slip_event_i[l];
					lof_q <= {7'h00, frame_loss_i[l]};
				end else begin
					if (crc_event_i[l] && (sc_q != `PMC_SEC_CRC_MAX)) begin
						sc_q <= sc_q + 10'h001;
					end
					if (oof_event_i[l]) begin
						oof_q <= 1'b1;
					end
					if (slip_event_i[l]) begin
						slip_q <= 1'b1;
					end
					if (frame_loss_i[l] && (lof_q != `PMC_SEC_LOF_MAX)) begin
						lof_q <= lof_q + 8'h01;
					end
				end
			end

			assign es = (sc_q != 10'h000) || oof_q || slip_q; // RULE25
			assign ses = (sc_q >= `PMC_SES_CRC_MIN) || oof_q; // RULE22
			assign bes = (sc_q >= `PMC_BES_CRC_MIN) &&
				(sc_q < `PMC_SES_CRC_MIN); // RULE23

			// failed state: the tenth severe second itself counts unavailable
			assign fail_d = ses ?
				(failed_q || (ses_run_q == `PMC_FAIL_RUN - 4'h1)) :
				(failed_q && (ok_run_q != `PMC_FAIL_RUN - 4'h1));
			always @(posedge core_clk_i or posedge rst_i) begin
				if (rst_i) begin
					ses_run_q <= 4'h0;
					ok_run_q <= 4'h0;
					failed_q <= 1'b0;
				end else if (sec_tick_i) begin
					failed_q <= fail_d; // RULE24
					if (ses) begin
						ok_run_q <= 4'h0;
						if (ses_run_q != `PMC_FAIL_RUN) begin
							ses_run_q <= ses_run_q + 4'h1;
						end
					end else begin
						ses_run_q <= 4'h0;
						if (ok_run_q != `PMC_FAIL_RUN) begin
							ok_run_q <= ok_run_q + 4'h1;
						end
					end
				end
			end

			assign int_add = {{15'h0000, slip_q}, {8'h00, lof_q},
				{15'h0000, bes}, {15'h0000, ses},
				{15'h0000, fail_d}, {15'h0000, es}};

			// fold happens the cycle after the 900th second is counted
			assign roll = tick_q && (elap_q == `PMC_SECS_PER_INT); // RULE27
			assign new_day = roll && (intv_q == `PMC_INT_PER_DAY);

			always @(posedge core_clk_i or posedge rst_i) begin
				if (rst_i) begin
					elap_q <= 10'h000;
					intv_q <= 7'h00;
				end else if (clr_corr) begin
					elap_q <= 10'h000;
					intv_q <= 7'h00;
				end else if (roll) begin
					elap_q <= 10'h000; // RULE27
					intv_q <= new_day ? 7'h01 : intv_q + 7'h01; // RULE8
				end else if (sec_tick_i) begin
					elap_q <= elap_q + 10'h001; // RULE3
				end
			end

			for (k = 0; k < 6; k = k + 1) begin : g_stat
				// RULE1 RULE2 RULE4: interval counts refresh on each tick
				pmc_sat_cnt #(
					.W(16),
					.MAX((k == 0) ? `PMC_INT_ES_MAX :
						(k < 4) ? `PMC_INT_SEC_MAX : `PMC_EVT_MAX)
				) u_int (
					.core_clk_i(core_clk_i),
					.rst_i(rst_i),
					.clr_i(clr_corr || roll),
					.en_i(sec_tick_i),
					.ld_i(1'b0),
					.add_i(int_add[16*k +: 16]),
					.cnt_o(int_v[16*k +: 16])
				);
				// RULE5 RULE6 RULE7: daily totals refresh at each fold
				pmc_sat_cnt #(
					.W(16),
					.MAX((k == 0) ? `PMC_DAY_ES_MAX :
						(k < 4) ? `PMC_DAY_SEC_MAX : `PMC_EVT_MAX)
				) u_day (
					.core_clk_i(core_clk_i),
					.rst_i(rst_i),
					.clr_i(clr_corr),
					.en_i(roll),
					.ld_i(new_day),
					.add_i(int_v[16*k +: 16]),
					.cnt_o(day_v[16*k +: 16])
				);
			end

			// RULE9: events are added once per second, only on CRC links
			pmc_sat_cnt #(
				.W(16),
				.MAX(`PMC_CRC_MAX)
			) u_crc (
				.core_clk_i(core_clk_i),
				.rst_i(rst_i),
				.clr_i(clr_crc),
				.en_i(sec_tick_i && crc_enable_i[l]),
				.ld_i(1'b0),
				.add_i({6'h00, sc_q}),
				.cnt_o(crc_cnt)
			);

			// average by repeated subtraction; one second leaves ample time
			always @(posedge core_clk_i or posedge rst_i) begin
				if (rst_i) begin
					sum_q <= 32'h00000000;
					secs_q <= 20'h00000;
					rem_q <= 32'h00000000;
					quo_q <= 10'h000;
					avg_q <= 10'h000;
					dv_busy_q <= 1'b0;
				end else if (clr_avg) begin
					sum_q <= 32'h00000000;
					secs_q <= 20'h00000;
					avg_q <= 10'h000;
					dv_busy_q <= 1'b0;
				end else if (sec_tick_i) begin
					if (crc_enable_i[l] && (secs_q != `PMC_AVG_SECS_MAX)) begin
						sum_q <= sum_q + {22'h000000, sc_q};
						secs_q <= secs_q + 20'h00001;
					end
				end else if (tick_q) begin
					rem_q <= sum_q;
					quo_q <= 10'h000;
					dv_busy_q <= (secs_q != 20'h00000);
				end else if (dv_busy_q) begin
					if ((rem_q >= {12'h000, secs_q}) &&
						(quo_q != `PMC_AVG_MAX)) begin
						rem_q <= rem_q - {12'h000, secs_q};
						quo_q <= quo_q + 10'h001;
					end else begin
						avg_q <= quo_q; // RULE10
						dv_busy_q <= 1'b0;
					end
				end
			end

			// a minute result wins over a clear landing in the same cycle
			always @(posedge core_clk_i or posedge rst_i) begin
				if (rst_i) begin
					bpv_q <= 14'h0000;
					bpv_last_q <= 14'h0000;
					bpv_peak_q <= 14'h0000;
				end else if (min_tick) begin
					bpv_q <= {13'h0000, bpv_event_i[l]};
					bpv_last_q <= bpv_q; // RULE11
					if (clr_bpv || (bpv_q > bpv_peak_q)) begin
						bpv_peak_q <= bpv_q; // RULE12
					end
				end else begin
					if (bpv_event_i[l] && (bpv_q != `PMC_BPV_MAX)) begin
						bpv_q <= bpv_q + 14'h0001;
					end
					if (clr_bpv) begin
						bpv_last_q <= 14'h0000; // RULE19
						bpv_peak_q <= 14'h0000; // RULE19
					end
				end
			end

			// a minute above the error-rate threshold is degraded
			assign min_deg = min_tick && (bpv_q > `PMC_DEG_BPV_LIMIT);
			pmc_sat_cnt #(
				.W(16),
				.MAX(`PMC_DEG_MAX)
			) u_deg (
				.core_clk_i(core_clk_i),
				.rst_i(rst_i),
				.clr_i(clr_corr),
				.en_i(min_deg || new_day),
				.ld_i(new_day),
				.add_i({15'h0000, min_deg}),
				.cnt_o(deg_today)
			); // RULE13

			always @(posedge core_clk_i or posedge rst_i) begin
				if (rst_i) begin
					deg_prev_q <= `PMC_CNT_RST;
				end else if (clr_corr) begin
					deg_prev_q <= `PMC_CNT_RST;
				end else if (new_day) begin
					deg_prev_q <= deg_today; // RULE14
				end
			end

			always @* begin
				lv = `PMC_CNT_RST;
				case (item_q)
					`PMC_IT_INT_ES: lv = int_v[15:0];
					`PMC_IT_INT_UAS: lv = int_v[31:16];
					`PMC_IT_ELAPSED: lv = {6'h00, elap_q};
					`PMC_IT_INT_SES: lv = int_v[47:32];
					`PMC_IT_INT_BES: lv = int_v[63:48];
					`PMC_IT_INT_LOF: lv = int_v[79:64];
					`PMC_IT_INT_CSS: lv = int_v[95:80];
					`PMC_IT_DAY_ES: lv = day_v[15:0];
					`PMC_IT_DAY_UAS: lv = day_v[31:16];
					`PMC_IT_DAY_SES: lv = day_v[47:32];
					`PMC_IT_DAY_BES: lv = day_v[63:48];
					`PMC_IT_DAY_LOF: lv = day_v[79:64];
					`PMC_IT_DAY_CSS: lv = day_v[95:80];
					`PMC_IT_DAY_INT: lv = {9'h000, intv_q};
					`PMC_IT_CRC_CNT: lv = crc_cnt;
					`PMC_IT_CRC_AVG: lv = {6'h00, avg_q};
					`PMC_IT_DEG_TODAY: lv = deg_today;
					`PMC_IT_DEG_PREV: lv = deg_prev_q;
					`PMC_IT_BPV_LAST: lv = {2'h0, bpv_last_q};
					`PMC_IT_BPV_PEAK: lv = {2'h0, bpv_peak_q};
					default: lv = `PMC_CNT_RST;
				endcase
			end
			assign link_val[16*l +: 16] = lv;
		end
	endgenerate
endmodule // pmc_top
`default_nettype wire

/* File: dv/pmc_framer_model.sv */
// framer stand-in: a burst of one-cycle event pulses on one link.
// assumes one burst request at a time from the bench on the core clock.
`timescale 1ns/1ps
`default_nettype none
module pmc_framer_model (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic [1:0] link_i,
	input wire logic [2:0] kind_i,
	input wire logic [15:0] n_i,
	input wire logic gap_i,
	output logic [3:0] crc_event_o,
	output logic [3:0] oof_event_o,
	output logic [3:0] slip_event_o,
	output logic [3:0] frame_loss_o,
	output logic [3:0] bpv_event_o,
	output logic busy_o
);
	logic [15:0] left_q;
	logic [2:0] kind_q;
	logic [1:0] link_q;
	logic gap_q;
	logic rest_q;
	logic [3:0] pulse_q;
	// a slow framer leaves an idle cycle between events
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			left_q <= 16'h0000;
			kind_q <= 3'h0;
			link_q <= 2'h0;
			gap_q <= 1'b0;
			rest_q <= 1'b0;
			pulse_q <= 4'h0;
		end else begin
			pulse_q <= 4'h0;
			rest_q <= 1'b0;
			if (go_i) begin
				left_q <= n_i;
				kind_q <= kind_i;
				link_q <= link_i;
				gap_q <= gap_i;
			end else if (left_q != 16'h0000 && !rest_q) begin
				pulse_q <= 4'h1 << link_q;
				left_q <= left_q - 16'h0001;
				rest_q <= gap_q;
			end
		end
	end
	assign crc_event_o = kind_q == 3'h0 ? pulse_q : 4'h0;
	assign oof_event_o = kind_q == 3'h1 ? pulse_q : 4'h0;
	assign slip_event_o = kind_q == 3'h2 ? pulse_q : 4'h0;
	assign frame_loss_o = kind_q == 3'h3 ? pulse_q : 4'h0;
	assign bpv_event_o = kind_q == 3'h4 ? pulse_q : 4'h0;
	assign busy_o = left_q != 16'h0000;
endmodule // pmc_framer_model
`default_nettype wire

/* File: dv/pmc_props.sv */
// checker for readout selection, clearing and failed-state timing.
// bound to pmc_top below; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module pmc_props (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic sec_tick_i,
	input wire logic [3:0] crc_enable_i,
	input wire logic [3:0] crc_event_i,
	input wire logic [3:0] oof_event_i,
	input wire logic [3:0] slip_event_i,
	input wire logic [3:0] frame_loss_i,
	input wire logic [3:0] bpv_event_i,
	input wire logic [1:0] link_sel_i,
	input wire logic item_step_i,
	input wire logic clear_key_i,
	input wire logic clear_all_i,
	input wire logic [15:0] item_value_o,
	input wire logic [4:0] item_code_o,
	input wire logic [1:0] item_link_o,
	input wire logic [3:0] link_failed_o
);
	// the average engine may still write for about 1000 cycles after a tick
	logic [10:0] quiet_q;
	logic calm;
	logic same;
	logic crc_now;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			quiet_q <= 11'h7ff;
		else if (sec_tick_i)
			quiet_q <= 11'h000;
		else if (quiet_q != 11'h7ff)
			quiet_q <= quiet_q + 11'h001;
	end
	assign calm = quiet_q > 11'h41a && !sec_tick_i;
	assign same = link_sel_i == item_link_o;
	assign crc_now = crc_enable_i[item_link_o];

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_all_clr;
		clear_all_i && calm && same && !item_step_i ##1 !sec_tick_i;
	endsequence
	sequence s_key_clr;
		clear_key_i && calm && same && !item_step_i &&
		(item_code_o <= 5'h0d || item_code_o >= 5'h10 ||
		(item_code_o == 5'h0e && crc_now)) ##1 !sec_tick_i;
	endsequence

	a_link_follows: assert property (!$past(rst_i) |->
		item_link_o == $past(link_sel_i))
		else $error("shown link does not follow selection");
	a_bpv_list: assert property ((!crc_now && $stable(item_link_o)) [*3]
		|-> item_code_o >= 5'h10)
		else $error("non-crc link shows a crc item");
	a_crc_list: assert property ((crc_now && $stable(item_link_o)) [*3]
		|-> item_code_o <= 5'h11)
		else $error("crc link shows a bipolar item");
	a_step_next: assert property (item_step_i && same &&
		item_code_o != 5'h11 && item_code_o != 5'h13 &&
		(crc_now ? item_code_o <= 5'h11 : item_code_o >= 5'h10)
		|=> item_code_o == $past(item_code_o) + 5'h01)
		else $error("step did not advance the item");
	a_crc_wrap: assert property (item_step_i && same && crc_now &&
		item_code_o == 5'h11 |=> item_code_o == 5'h00)
		else $error("crc item list did not wrap");
	a_bpv_wrap: assert property (item_step_i && same && !crc_now &&
		item_code_o == 5'h13 |=> item_code_o == 5'h10)
		else $error("bipolar item list did not wrap");
	a_all_cleared: assert property (s_all_clr |=>
		item_value_o == 16'h0000)
		else $error("clear-all left a nonzero value");
	a_key_cleared: assert property (s_key_clr |=>
		item_value_o == 16'h0000)
		else $error("key clear left the shown item nonzero");
	a_fail_on_tick: assert property (!$past(rst_i) &&
		!$past(sec_tick_i) && !$past(sec_tick_i, 2) &&
		!$past(clear_all_i) && !$past(clear_all_i, 2) &&
		!$past(clear_key_i) && !$past(clear_key_i, 2)
		|-> $stable(link_failed_o))
		else $error("failed state moved without a tick");
endmodule // pmc_props

bind pmc_top pmc_props u_pmc_props (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .sec_tick_i(sec_tick_i),
	.crc_enable_i(crc_enable_i), .crc_event_i(crc_event_i),
	.oof_event_i(oof_event_i), .slip_event_i(slip_event_i),
	.frame_loss_i(frame_loss_i), .bpv_event_i(bpv_event_i),
	.link_sel_i(link_sel_i), .item_step_i(item_step_i),
	.clear_key_i(clear_key_i), .clear_all_i(clear_all_i),
	.item_value_o(item_value_o), .item_code_o(item_code_o),
	.item_link_o(item_link_o), .link_failed_o(link_failed_o));
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the statistics bank with a framer stand-in.
// assumes the checker binds itself; links 0 and 2 run with crc checking.
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {
		logic [1:0] el;
		logic [2:0] k;
		logic [15:0] n;
		logic [1:0] rl;
		logic [4:0] it;
		logic [15:0] ex;
	} pmc_row_t;
	logic core_clk_i, rst_i, sec_tick_i, item_step_i, clear_key_i;
	logic clear_all_i, go, gap, busy;
	logic [1:0] link_sel_i, ev_link, item_link_o;
	logic [2:0] ev_kind;
	logic [15:0] ev_n, item_value_o;
	logic [3:0] crc_ev, oof_ev, slip_ev, lof_ev, bpv_ev, link_failed_o;
	logic [4:0] item_code_o;
	int mismatches, n_checks, n_ticks;
	pmc_row_t rows [14];

	pmc_framer_model u_pmc_framer_model (.core_clk_i(core_clk_i),
		.rst_i(rst_i), .go_i(go), .link_i(ev_link), .kind_i(ev_kind),
		.n_i(ev_n), .gap_i(gap), .crc_event_o(crc_ev), .oof_event_o(oof_ev),
		.slip_event_o(slip_ev), .frame_loss_o(lof_ev),
		.bpv_event_o(bpv_ev), .busy_o(busy));
	pmc_top u_pmc_top (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.sec_tick_i(sec_tick_i), .crc_enable_i(4'h5), .crc_event_i(crc_ev),
		.oof_event_i(oof_ev), .slip_event_i(slip_ev), .frame_loss_i(lof_ev),
		.bpv_event_i(bpv_ev), .link_sel_i(link_sel_i),
		.item_step_i(item_step_i), .clear_key_i(clear_key_i),
		.clear_all_i(clear_all_i), .item_value_o(item_value_o),
		.item_code_o(item_code_o), .item_link_o(item_link_o),
		.link_failed_o(link_failed_o));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	// ticks stay 1100 cycles apart so the average always finishes
	task automatic tick();
		@(posedge core_clk_i);
		sec_tick_i <= 1'b1;
		@(posedge core_clk_i);
		sec_tick_i <= 1'b0;
		n_ticks++;
		cyc(1100);
	endtask
	task automatic burst(input logic [1:0] l, input logic [2:0] k,
		input logic [15:0] n);
		@(posedge core_clk_i);
		go <= 1'b1;
		ev_link <= l;
		ev_kind <= k;
		ev_n <= n;
		gap <= n < 16'h0004;
		@(posedge core_clk_i);
		go <= 1'b0;
		cyc(1);
		for (int i = 0; busy; i++) begin
			if (i > 2500) begin
				mismatches++;
				complete_run();
			end
			cyc(1);
		end
	endtask
	task automatic clr(input logic all);
		@(posedge core_clk_i);
		clear_all_i <= all;
		clear_key_i <= !all;
		@(posedge core_clk_i);
		clear_all_i <= 1'b0;
		clear_key_i <= 1'b0;
		cyc(3);
	endtask
	task automatic step();
		@(posedge core_clk_i);
		item_step_i <= 1'b1;
		@(posedge core_clk_i);
		item_step_i <= 1'b0;
		cyc(2);
	endtask
	task automatic sel(input logic [1:0] l, input logic [4:0] it);
		@(posedge core_clk_i);
		link_sel_i <= l;
		cyc(3);
		for (int i = 0; item_code_o !== it; i++) begin
			if (i > 24) begin
				mismatches++;
				complete_run();
			end
			step();
		end
	endtask

	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end
	initial begin
		rows[0] = {2'h0, 3'h0, 16'h0001, 2'h0, 5'h00, 16'h0001};
		rows[1] = {2'h0, 3'h0, 16'h0002, 2'h0, 5'h04, 16'h0001};
		rows[2] = {2'h0, 3'h0, 16'h033f, 2'h0, 5'h04, 16'h0001};
		rows[3] = {2'h0, 3'h0, 16'h033f, 2'h0, 5'h03, 16'h0000};
		rows[4] = {2'h0, 3'h0, 16'h0340, 2'h0, 5'h03, 16'h0001};
		rows[5] = {2'h0, 3'h1, 16'h0001, 2'h0, 5'h03, 16'h0001};
		rows[6] = {2'h0, 3'h2, 16'h0003, 2'h0, 5'h00, 16'h0001};
		rows[7] = {2'h0, 3'h2, 16'h0003, 2'h0, 5'h06, 16'h0001};
		rows[8] = {2'h0, 3'h3, 16'h012c, 2'h0, 5'h05, 16'h00ff};
		rows[9] = {2'h2, 3'h0, 16'h0005, 2'h2, 5'h0e, 16'h0005};
		rows[10] = {2'h2, 3'h0, 16'h0005, 2'h0, 5'h0e, 16'h0000};
		rows[11] = {2'h0, 3'h0, 16'h03ff, 2'h0, 5'h0e, 16'h03e8};
		rows[12] = {2'h0, 3'h0, 16'h0007, 2'h0, 5'h0f, 16'h0007};
		rows[13] = {2'h0, 3'h1, 16'h0001, 2'h0, 5'h02, 16'h0001};
		{rst_i, sec_tick_i, item_step_i, clear_key_i, clear_all_i} = 5'h10;
		{go, gap, link_sel_i, ev_link, ev_kind, ev_n} = 25'h0;
		repeat (6) @(posedge core_clk_i);
		rst_i <= 1'b0;
		cyc(4);
		chk({11'h000, item_code_o}, 16'h0000);
		chk(item_value_o, 16'h0000);
		foreach (rows[i]) begin
			clr(1'b1);
			burst(rows[i].el, rows[i].k, rows[i].n);
			tick();
			sel(rows[i].rl, rows[i].it);
			chk(item_value_o, rows[i].ex);
		end
		clr(1'b1);
		burst(2'h0, 3'h0, 16'h0004);
		tick();
		sel(2'h0, 5'h0e);
		clr(1'b0);
		chk(item_value_o, 16'h0000);
		sel(2'h0, 5'h00);
		chk(item_value_o, 16'h0001);
		clr(1'b0);
		sel(2'h0, 5'h02);
		chk(item_value_o, 16'h0000);
		clr(1'b1);
		for (int s = 1; s <= 20; s++) begin
			if (s <= 10)
				burst(2'h0, 3'h1, 16'h0001);
			tick();
			if (s == 9 || s == 10 || s >= 19)
				chk({15'h0, link_failed_o[0]}, {15'h0, s >= 10 && s < 20});
		end
		sel(2'h0, 5'h01);
		chk(item_value_o, 16'h000a);
		@(posedge core_clk_i);
		link_sel_i <= 2'h1;
		cyc(3);
		chk({11'h000, item_code_o}, 16'h0010);
		chk({14'h0000, item_link_o}, 16'h0001);
		clr(1'b1);
		burst(2'h1, 3'h4, 16'h0082);
		while (n_ticks < 60)
			tick();
		sel(2'h1, 5'h12);
		chk(item_value_o, 16'h0082);
		sel(2'h1, 5'h13);
		chk(item_value_o, 16'h0082);
		sel(2'h1, 5'h10);
		chk(item_value_o, 16'h0001);
		sel(2'h1, 5'h12);
		clr(1'b0);
		sel(2'h1, 5'h13);
		chk(item_value_o, 16'h0000);
		sel(2'h1, 5'h10);
		chk(item_value_o, 16'h0001);
		clr(1'b0);
		chk(item_value_o, 16'h0000);
		clr(1'b1);
		burst(2'h0, 3'h2, 16'h0001);
		// ticks may come fast here: the crc sums stay zero after the clear, so every average is zero
		repeat (900) begin
			@(posedge core_clk_i);
			sec_tick_i <= 1'b1;
			@(posedge core_clk_i);
			sec_tick_i <= 1'b0;
		end
		cyc(4);
		sel(2'h0, 5'h07);
		chk(item_value_o, 16'h0001);
		sel(2'h0, 5'h0c);
		chk(item_value_o, 16'h0001);
		sel(2'h0, 5'h0d);
		chk(item_value_o, 16'h0001);
		sel(2'h0, 5'h00);
		chk(item_value_o, 16'h0000);
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		cyc(3);
		@(posedge core_clk_i);
		rst_i <= 1'b0;
		cyc(4);
		chk({11'h000, item_code_o}, 16'h0000);
		chk(item_value_o, 16'h0000);
		chk({12'h000, link_failed_o}, 16'h0000);
		complete_run();
	end
endmodule // tb
`default_nettype wire
